//--- logic/gcp_pkg.sv
// shared constants and types of the coprocessor bus handover block
`default_nettype none
package gcp_pkg;

  // ---------------------------------------------------------------
  // widths and sizes
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int NUM_REGS = 16;
  localparam int REG_IDX_W = 4;
  localparam int PC_IDX = 15;
  localparam int R0_IDX = 0;
  localparam int CACHE_BYTES = 512;
  localparam int CACHE_AW = 9;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam int CORE_CLK_KHZ = 10740;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] PC_STEP = 16'h0001;

  // ---------------------------------------------------------------
  // opcodes: high nibble selects the operation, low nibble a register
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_CTRL = 4'h0;
  localparam logic [3:0] OP_ADD = 4'h2;
  localparam logic [3:0] OP_SUB = 4'h3;
  localparam logic [3:0] OP_AND = 4'h4;
  localparam logic [3:0] OP_OR = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_MOVE = 4'h7;
  localparam logic [3:0] OP_ROMRD = 4'h8;
  localparam logic [3:0] OP_GETB = 4'h9;
  localparam logic [3:0] OP_STW = 4'ha;
  localparam logic [3:0] OP_LDW = 4'hb;
  localparam logic [3:0] CTRL_STOP = 4'h0;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int STATUS_W = 3;
  localparam int ST_OWN = 0;
  localparam int ST_RUN = 1;
  localparam int ST_IRQ = 2;

  typedef enum logic [2:0] {
    ALU_ADD,
    ALU_SUB,
    ALU_AND,
    ALU_OR,
    ALU_XOR,
    ALU_PASS
  } gcp_alu_op_t;

  typedef enum logic [1:0] {
    GCP_IDLE,
    GCP_RUN,
    GCP_FETCHW,
    GCP_EXEC
  } gcp_state_t;

endpackage
`default_nettype wire

//--- logic/gcp_alu.sv
// 16-bit arithmetic and logic operator of the coprocessor
`timescale 1ns/1ps
`default_nettype none
module gcp_alu
  import gcp_pkg::*;
#(
  parameter int W = DATA_W
)
(
  input wire logic [W-1:0] opA,
  input wire logic [W-1:0] opB,
  input wire gcp_alu_op_t aluOp,
  output logic [W-1:0] result
);

  initial
  begin
    if (W < 1) $error("operator width must be positive");
  end

  always_comb
  begin
    unique case (aluOp)
      ALU_ADD: result = opA + opB;
      ALU_SUB: result = opA - opB;
      ALU_AND: result = opA & opB;
      ALU_OR: result = opA | opB;
      ALU_XOR: result = opA ^ opB;
      ALU_PASS: result = opB;
      default: result = opA;
    endcase
  end

endmodule
`default_nettype wire

//--- logic/gcp_bus_handover.sv
// coprocessor core with host interface and shared rom/ram bus handover
//
// Overview of operation
// - Console reset puts the coprocessor into its reset state.
// - After reset the buses belong to the host and the core is idle.
// - Host and coprocessor never use shared rom or ram in one cycle.
// - A host-written ownership flag decides who owns the rom and ram buses.
// - With the flag set, the core fetches from rom and writes results to ram.
// - The stop instruction halts processing and raises a host interrupt.
// - On stop the rom and ram buses return to the host.
// - A 512-byte instruction cache holds code for fast execution.
// - Single-byte instructions from the cache finish in one cycle.
// - Sixteen 16-bit general registers carry all operations.
// - The operator does 16-bit arithmetic and logic.
// - Separate rom and ram ports may work at the same time.
// - Rom data reads go through a buffer while execution continues.
// - Ram writes go through a buffer while execution continues; ram loads stall execution until the data returns.
// - Core clock runs at 10.74 MHz.
// - The host can load instruction bytes into the cache while the core is idle.
// - A host program counter write while idle starts execution.
// - Status flags stay readable by the host while running.
`timescale 1ns/1ps
`default_nettype none
module gcp_bus_handover
  import gcp_pkg::*;
#(
  parameter int CACHE_SIZE = CACHE_BYTES
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic hostOwnWr,
  input wire logic hostOwnVal,
  input wire logic hostPcWr,
  input wire logic [DATA_W-1:0] hostPcData,
  input wire logic hostCacheWr,
  input wire logic [CACHE_AW-1:0] hostCacheAddr,
  input wire logic [BYTE_W-1:0] hostCacheData,
  input wire logic hostStatusRd,
  output logic [STATUS_W-1:0] statusFlags,
  output logic hostIrq,
  input wire logic hostRomReq,
  input wire logic [ADDR_W-1:0] hostRomAddr,
  output logic [BYTE_W-1:0] hostRomData,
  output logic hostRomAck,
  input wire logic hostRamReq,
  input wire logic hostRamWe,
  input wire logic [ADDR_W-1:0] hostRamAddr,
  input wire logic [DATA_W-1:0] hostRamWrData,
  output logic [DATA_W-1:0] hostRamRdData,
  output logic hostRamAck,
  output logic romReq,
  output logic [ADDR_W-1:0] romAddr,
  input wire logic [BYTE_W-1:0] romRdData,
  input wire logic romAck,
  output logic ramReq,
  output logic ramWe,
  output logic [ADDR_W-1:0] ramAddr,
  output logic [DATA_W-1:0] ramWrData,
  input wire logic [DATA_W-1:0] ramRdData,
  input wire logic ramAck
);

  initial
  begin
    if (CACHE_SIZE != CACHE_BYTES) $error("cache size must match the cache index width");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  gcp_state_t state_r, state_nxt;
  logic [DATA_W-1:0] regs_r [NUM_REGS];
  logic [DATA_W-1:0] regs_nxt [NUM_REGS];
  logic [BYTE_W-1:0] cache_r [CACHE_SIZE];
  logic [BYTE_W-1:0] cache_nxt [CACHE_SIZE];
  logic own_r, own_nxt;
  logic busCop_r, busCop_nxt;
  logic irq_r, irq_nxt;
  logic run_r, run_nxt;
  logic [BYTE_W-1:0] instrReg_r, instrReg_nxt;
  logic romFetch_r, romFetch_nxt;
  logic romBufPend_r, romBufPend_nxt;
  logic [BYTE_W-1:0] romBuf_r, romBuf_nxt;
  logic ramLoadWait_r, ramLoadWait_nxt;
  logic romReq_r, romReq_nxt;
  logic [ADDR_W-1:0] romAddr_r, romAddr_nxt;
  logic ramReq_r, ramReq_nxt;
  logic ramWe_r, ramWe_nxt;
  logic [ADDR_W-1:0] ramAddr_r, ramAddr_nxt;
  logic [DATA_W-1:0] ramWrData_r, ramWrData_nxt;
  logic hostRomAck_r, hostRomAck_nxt;
  logic [BYTE_W-1:0] hostRomData_r, hostRomData_nxt;
  logic hostRamAck_r, hostRamAck_nxt;
  logic [DATA_W-1:0] hostRamRdData_r, hostRamRdData_nxt;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] pc;
  logic inCache;
  logic [BYTE_W-1:0] instr;
  logic [3:0] opc;
  logic [REG_IDX_W-1:0] rn;
  logic instrValid;
  gcp_alu_op_t aluOp;
  logic [DATA_W-1:0] aluResult;
  logic hostPass;

  assign pc = regs_r[PC_IDX];
  assign inCache = (pc < DATA_W'(CACHE_SIZE));
  assign instr = (state_r == GCP_EXEC) ? instrReg_r : cache_r[pc[CACHE_AW-1:0]];
  assign opc = instr[7:4];
  assign rn = instr[3:0];
  // cached code decodes and retires in the same cycle
  assign instrValid = busCop_r &&
    ((state_r == GCP_RUN && inCache) || state_r == GCP_EXEC);
  assign hostPass = !busCop_r && !own_r;

  always_comb
  begin
    unique case (opc)
      OP_ADD: aluOp = ALU_ADD;
      OP_SUB: aluOp = ALU_SUB;
      OP_AND: aluOp = ALU_AND;
      OP_OR: aluOp = ALU_OR;
      OP_XOR: aluOp = ALU_XOR;
      default: aluOp = ALU_PASS;
    endcase
  end

  gcp_alu #(
    .W(DATA_W)
  ) u_alu (
    .opA(regs_r[R0_IDX]),
    .opB(regs_r[rn]),
    .aluOp(aluOp),
    .result(aluResult)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    regs_nxt = regs_r;
    cache_nxt = cache_r;
    own_nxt = own_r;
    irq_nxt = irq_r;
    instrReg_nxt = instrReg_r;
    romFetch_nxt = romFetch_r;
    romBufPend_nxt = romBufPend_r;
    romBuf_nxt = romBuf_r;
    ramLoadWait_nxt = ramLoadWait_r;
    romReq_nxt = romReq_r & ~romAck;
    romAddr_nxt = romAddr_r;
    ramReq_nxt = ramReq_r & ~ramAck;
    ramWe_nxt = ramWe_r;
    ramAddr_nxt = ramAddr_r;
    ramWrData_nxt = ramWrData_r;
    hostRomAck_nxt = romAck && romReq_r && !busCop_r;
    hostRomData_nxt = hostRomData_r;
    hostRamAck_nxt = ramAck && ramReq_r && !busCop_r;
    hostRamRdData_nxt = hostRamRdData_r;

    // owner switches only when neither port has a transfer in flight
    busCop_nxt = busCop_r;
    if (!romReq_r && !ramReq_r)
      busCop_nxt = own_r;

    if (hostOwnWr)
      own_nxt = hostOwnVal;

    // host pass-through, only while the host owns the buses
    if (hostPass)
    begin
      romReq_nxt = hostRomReq & ~romAck & ~hostRomAck_r;
      romAddr_nxt = hostRomAddr;
      ramReq_nxt = hostRamReq & ~ramAck & ~hostRamAck_r;
      ramWe_nxt = hostRamWe;
      ramAddr_nxt = hostRamAddr;
      ramWrData_nxt = hostRamWrData;
    end
    if (romAck && romReq_r && !busCop_r)
      hostRomData_nxt = romRdData;
    if (ramAck && ramReq_r && !busCop_r)
      hostRamRdData_nxt = ramRdData;

    // coprocessor port completions
    if (romAck && romReq_r && busCop_r)
    begin
      if (romFetch_r)
      begin
        instrReg_nxt = romRdData;
        romFetch_nxt = 1'b0;
        state_nxt = GCP_EXEC;
      end
      else
      begin
        romBuf_nxt = romRdData;
        romBufPend_nxt = 1'b0;
      end
    end
    if (ramAck && ramReq_r && busCop_r && ramLoadWait_r)
    begin
      regs_nxt[R0_IDX] = ramRdData;
      ramLoadWait_nxt = 1'b0;
    end

    if (hostStatusRd)
      irq_nxt = 1'b0;

    unique case (state_r)
      GCP_IDLE:
      begin
        if (hostCacheWr)
          cache_nxt[hostCacheAddr] = hostCacheData;
        if (hostPcWr)
        begin
          regs_nxt[PC_IDX] = hostPcData;
          state_nxt = GCP_RUN;
        end
      end
      GCP_RUN:
      begin
        // code outside the cache is fetched over the rom port
        if (busCop_r && !inCache && !romReq_r && !ramLoadWait_r)
        begin
          romReq_nxt = 1'b1;
          romAddr_nxt = pc;
          romFetch_nxt = 1'b1;
          state_nxt = GCP_FETCHW;
        end
      end
      GCP_FETCHW:
      begin
      end
      GCP_EXEC:
      begin
      end
    endcase

    // execute one instruction unless a buffer is still busy
    if (instrValid && !ramLoadWait_r)
    begin
      if (!((opc == OP_GETB && romBufPend_r) ||
            (opc == OP_ROMRD && (romReq_r || romBufPend_r)) ||
            ((opc == OP_STW || opc == OP_LDW) && ramReq_r)))
      begin
        regs_nxt[PC_IDX] = pc + PC_STEP;
        state_nxt = GCP_RUN;
        unique case (opc)
          OP_CTRL:
          begin
            if (rn == CTRL_STOP)
            begin
              state_nxt = GCP_IDLE;
              irq_nxt = 1'b1;
              own_nxt = 1'b0;
            end
          end
          OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR:
            regs_nxt[R0_IDX] = aluResult;
          OP_MOVE:
            regs_nxt[rn] = regs_r[R0_IDX];
          OP_ROMRD:
          begin
            romReq_nxt = 1'b1;
            romAddr_nxt = regs_r[rn];
            romFetch_nxt = 1'b0;
            romBufPend_nxt = 1'b1;
          end
          OP_GETB:
            regs_nxt[R0_IDX] = {BYTE_RST, romBuf_r};
          OP_STW:
          begin
            ramReq_nxt = 1'b1;
            ramWe_nxt = 1'b1;
            ramAddr_nxt = regs_r[rn];
            ramWrData_nxt = regs_r[R0_IDX];
          end
          OP_LDW:
          begin
            ramReq_nxt = 1'b1;
            ramWe_nxt = 1'b0;
            ramAddr_nxt = regs_r[rn];
            ramLoadWait_nxt = 1'b1;
          end
          default:
          begin
          end
        endcase
      end
    end
    run_nxt = (state_nxt != GCP_IDLE);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= GCP_IDLE;
      for (int i = 0; i < NUM_REGS; i++)
        regs_r[i] <= REG_RST;
      for (int i = 0; i < CACHE_SIZE; i++)
        cache_r[i] <= BYTE_RST;
      own_r <= 1'b0;
      busCop_r <= 1'b0;
      irq_r <= 1'b0;
      run_r <= 1'b0;
      instrReg_r <= BYTE_RST;
      romFetch_r <= 1'b0;
      romBufPend_r <= 1'b0;
      romBuf_r <= BYTE_RST;
      ramLoadWait_r <= 1'b0;
      romReq_r <= 1'b0;
      romAddr_r <= ADDR_RST;
      ramReq_r <= 1'b0;
      ramWe_r <= 1'b0;
      ramAddr_r <= ADDR_RST;
      ramWrData_r <= REG_RST;
      hostRomAck_r <= 1'b0;
      hostRomData_r <= BYTE_RST;
      hostRamAck_r <= 1'b0;
      hostRamRdData_r <= REG_RST;
    end
    else if (clkEn)
    begin
      state_r <= state_nxt;
      regs_r <= regs_nxt;
      cache_r <= cache_nxt;
      own_r <= own_nxt;
      busCop_r <= busCop_nxt;
      irq_r <= irq_nxt;
      run_r <= run_nxt;
      instrReg_r <= instrReg_nxt;
      romFetch_r <= romFetch_nxt;
      romBufPend_r <= romBufPend_nxt;
      romBuf_r <= romBuf_nxt;
      ramLoadWait_r <= ramLoadWait_nxt;
      romReq_r <= romReq_nxt;
      romAddr_r <= romAddr_nxt;
      ramReq_r <= ramReq_nxt;
      ramWe_r <= ramWe_nxt;
      ramAddr_r <= ramAddr_nxt;
      ramWrData_r <= ramWrData_nxt;
      hostRomAck_r <= hostRomAck_nxt;
      hostRomData_r <= hostRomData_nxt;
      hostRamAck_r <= hostRamAck_nxt;
      hostRamRdData_r <= hostRamRdData_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // status stays visible in every state of the core
  assign statusFlags[ST_OWN] = busCop_r;
  assign statusFlags[ST_RUN] = run_r;
  assign statusFlags[ST_IRQ] = irq_r;
  assign hostIrq = irq_r;
  assign hostRomData = hostRomData_r;
  assign hostRomAck = hostRomAck_r;
  assign hostRamRdData = hostRamRdData_r;
  assign hostRamAck = hostRamAck_r;
  assign romReq = romReq_r;
  assign romAddr = romAddr_r;
  assign ramReq = ramReq_r;
  assign ramWe = ramWe_r;
  assign ramAddr = ramAddr_r;
  assign ramWrData = ramWrData_r;

endmodule
`default_nettype wire

//--- sim/gcp_bus_handover_asserts.sv
// assertion checker of the coprocessor bus handover block
`timescale 1ns/1ps
`default_nettype none
module gcp_bus_handover_asserts
  import gcp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hostPcWr,
  input wire logic hostStatusRd,
  input wire logic [STATUS_W-1:0] statusFlags,
  input wire logic hostIrq,
  input wire logic hostRomReq,
  input wire logic [ADDR_W-1:0] hostRomAddr,
  input wire logic [BYTE_W-1:0] hostRomData,
  input wire logic hostRomAck,
  input wire logic hostRamAck,
  input wire logic romReq,
  input wire logic [ADDR_W-1:0] romAddr,
  input wire logic [BYTE_W-1:0] romRdData,
  input wire logic romAck,
  input wire logic ramReq,
  input wire logic ramAck
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // --------
  // port relations
  // --------
  property p_rst_idle;
    $rose(rst_n) |-> statusFlags == 3'h0 && !hostIrq && !romReq && !ramReq;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy after reset");
  property p_host_excl;
    statusFlags[ST_OWN] && $past(statusFlags[ST_OWN]) |-> !hostRomAck && !hostRamAck;
  endproperty
  a_host_excl: assert property (p_host_excl) else $error("host served while owned");
  property p_rom_hs;
    romReq && romAck |=> !romReq;
  endproperty
  a_rom_hs: assert property (p_rom_hs) else $error("rom request held after ack");
  property p_ram_hs;
    ramReq && ramAck |=> !ramReq;
  endproperty
  a_ram_hs: assert property (p_ram_hs) else $error("ram request held after ack");
  property p_stop_irq;
    $rose(hostIrq) |-> statusFlags[ST_IRQ] && !statusFlags[ST_RUN];
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("irq without stop");
  property p_bus_back;
    $rose(hostIrq) |-> ##[1:20] !statusFlags[ST_OWN];
  endproperty
  a_bus_back: assert property (p_bus_back) else $error("buses not returned");
  property p_irq_hold;
    hostIrq && !hostStatusRd |=> hostIrq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped unread");
  property p_pc_start;
    hostPcWr && !statusFlags[ST_RUN] |=> statusFlags[ST_RUN];
  endproperty
  a_pc_start: assert property (p_pc_start) else $error("pc write did not start");
  property p_pass;
    $rose(hostRomReq) && !statusFlags[ST_OWN] |=> romReq && romAddr == $past(hostRomAddr);
  endproperty
  a_pass: assert property (p_pass) else $error("host rom request not passed");
  property p_rom_data;
    hostRomAck |-> $past(romAck) && hostRomData == $past(romRdData);
  endproperty
  a_rom_data: assert property (p_rom_data) else $error("host rom data wrong");
  c_stop: cover property ($rose(hostIrq));
  c_cop_rom: cover property (statusFlags[ST_OWN] && romAck);
  c_host_rom: cover property (hostRomAck);
endmodule
bind gcp_bus_handover gcp_bus_handover_asserts gcp_bus_handover_asserts_i (.clk_sys, .rst_n,
  .hostPcWr, .hostStatusRd, .statusFlags, .hostIrq, .hostRomReq, .hostRomAddr, .hostRomData,
  .hostRomAck, .hostRamAck, .romReq, .romAddr, .romRdData, .romAck, .ramReq, .ramAck);
`default_nettype wire

//--- sim/gcp_mem_model.sv
// behavioural cartridge rom and ram on the shared ports
`timescale 1ns/1ps
`default_nettype none
module gcp_mem_model
  import gcp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic romReq,
  input wire logic [ADDR_W-1:0] romAddr,
  output logic [BYTE_W-1:0] romRdData,
  output logic romAck,
  input wire logic ramReq,
  input wire logic ramWe,
  input wire logic [ADDR_W-1:0] ramAddr,
  input wire logic [DATA_W-1:0] ramWrData,
  output logic [DATA_W-1:0] ramRdData,
  output logic ramAck
);
  logic [DATA_W-1:0] mem [256];
  initial
  begin
    {romAck, ramAck, romRdData, ramRdData} = '0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // --------
  // ports answer on their own, so rom and ram overlap
  // --------
  always
  begin
    @(posedge clk_sys);
    if (romReq)
    begin
      repeat (slow ? 3 : 1) @(posedge clk_sys);
      romAck <= 1'b1;
      romRdData <= romAddr[7:0] ^ 8'h5a;
      @(posedge clk_sys);
      romAck <= 1'b0;
    end
    // data no longer driven does not keep the last byte
    romRdData <= ~romRdData;
  end
  always
  begin
    @(posedge clk_sys);
    if (ramReq)
    begin
      repeat (slow ? 3 : 1) @(posedge clk_sys);
      ramAck <= 1'b1;
      ramRdData <= mem[ramAddr[7:0]];
      if (ramWe)
        mem[ramAddr[7:0]] <= ramWrData;
      @(posedge clk_sys);
      ramAck <= 1'b0;
    end
    ramRdData <= ~ramRdData;
  end
endmodule
`default_nettype wire

//--- sim/gcp_bus_handover_tb.sv
// self-checking testbench of the coprocessor bus handover block
`timescale 1ns/1ps
`default_nettype none
module gcp_bus_handover_tb import gcp_pkg::*;;
  logic clk_sys, rst_n, clkEn, hostOwnWr, hostOwnVal, hostPcWr, hostCacheWr, hostStatusRd;
  logic hostRomReq, hostRamReq, hostRamWe, slow, irqSeen, hostIrq, hostRomAck, hostRamAck;
  logic romReq, romAck, ramReq, ramWe, ramAck;
  logic [DATA_W-1:0] hostPcData, hostRamWrData, hostRamRdData, ramWrData, ramRdData, x;
  logic [ADDR_W-1:0] hostRomAddr, hostRamAddr, romAddr, ramAddr, a;
  logic [CACHE_AW-1:0] hostCacheAddr;
  logic [BYTE_W-1:0] hostCacheData, hostRomData, romRdData, r;
  logic [STATUS_W-1:0] statusFlags;
  logic [1:0] kd;
  logic [17:0] nt;
  logic [17:0] notes [$];
  logic [7:0] prog [10] = '{8'h81, 8'h91, 8'h71, 8'h21, 8'h41, 8'h61, 8'h31, 8'h51, 8'ha2, 8'h00};
  int n_mismatch = 0;
  int n_tests = 0;
  int k;
  gcp_bus_handover gcp_bus_handover_i (.clk_sys, .rst_n, .clkEn, .hostOwnWr, .hostOwnVal,
    .hostPcWr, .hostPcData, .hostCacheWr, .hostCacheAddr, .hostCacheData, .hostStatusRd,
    .statusFlags, .hostIrq, .hostRomReq, .hostRomAddr, .hostRomData, .hostRomAck,
    .hostRamReq, .hostRamWe, .hostRamAddr, .hostRamWrData, .hostRamRdData, .hostRamAck,
    .romReq, .romAddr, .romRdData, .romAck, .ramReq, .ramWe, .ramAddr, .ramWrData,
    .ramRdData, .ramAck);
  gcp_mem_model gcp_mem_model_i (.clk_sys, .slow, .romReq, .romAddr, .romRdData, .romAck,
    .ramReq, .ramWe, .ramAddr, .ramWrData, .ramRdData, .ramAck);
  // --------
  // helpers
  // --------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // host access; d is the write data or the expected read data
  task automatic host_acc(input logic ram, input logic we, input logic [15:0] ad, d);
    int w;
    notes.push_back({ram ? (we ? 2'h2 : 2'h1) : 2'h0, d});
    @(posedge clk_sys);
    hostRomReq <= !ram;
    hostRamReq <= ram;
    hostRamWe <= we;
    hostRomAddr <= ad;
    hostRamAddr <= ad;
    hostRamWrData <= d;
    w = 0;
    do @(negedge clk_sys); while (!(hostRomAck || hostRamAck) && ++w < 300);
    @(posedge clk_sys);
    hostRomReq <= 1'b0;
    hostRamReq <= 1'b0;
  endtask
  task automatic start_run(input logic [15:0] pc);
    @(posedge clk_sys);
    hostOwnWr <= 1'b1;
    hostOwnVal <= 1'b1;
    @(posedge clk_sys);
    hostOwnWr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    hostPcWr <= 1'b1;
    hostPcData <= pc;
    @(posedge clk_sys);
    hostPcWr <= 1'b0;
    @(negedge clk_sys);
    check("owned and running", {13'h0, statusFlags}, 16'h0003);
  endtask
  // --------
  // result monitor
  // --------
  always @(negedge clk_sys)
  begin
    if (rst_n && (hostRomAck || hostRamAck || (hostIrq && !irqSeen)))
    begin
      kd = hostRomAck ? 2'h0 : (hostRamAck ? (hostRamWe ? 2'h2 : 2'h1) : 2'h3);
      nt = (notes.size() > 0) ? notes.pop_front() : 18'h0ffff;
      check("result kind", {14'h0, kd}, {14'h0, nt[17:16]});
      if (kd == 2'h0)
        check("host rom data", {8'h00, hostRomData}, nt[15:0]);
      if (kd == 2'h1)
        check("host ram data", hostRamRdData, nt[15:0]);
    end
    irqSeen <= rst_n && hostIrq;
  end
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    #(3000 * 100);
    n_mismatch++;
    give_verdict();
  end
  // --------
  // tests
  // --------
  initial
  begin
    {rst_n, hostOwnWr, hostOwnVal, hostPcWr, hostCacheWr, hostStatusRd, irqSeen} = '0;
    {hostRomReq, hostRamReq, hostRamWe, slow, hostPcData, hostCacheAddr, hostCacheData} = '0;
    {hostRomAddr, hostRamAddr, hostRamWrData} = '0;
    clkEn = 1'b1;
    k = $urandom(32'h558c);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    check("status after reset", {12'h0, hostIrq, statusFlags}, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      a = 16'($urandom);
      host_acc(1'b0, 1'b0, a, {8'h00, a[7:0] ^ 8'h5a});
    end
    a = {8'h01, 8'($urandom) | 8'h01};
    x = 16'($urandom);
    host_acc(1'b1, 1'b1, a, x);
    host_acc(1'b1, 1'b0, a, x);
    $display("test host traffic done");
    foreach (prog[i])
    begin
      @(posedge clk_sys);
      hostCacheWr <= 1'b1;
      hostCacheAddr <= 9'(i);
      hostCacheData <= prog[i];
    end
    @(posedge clk_sys);
    hostCacheWr <= 1'b0;
    slow <= 1'b1;
    r = 8'h5a;
    x = {8'h00, r} + {8'h00, r};
    x = (((x & {8'h00, r}) ^ {8'h00, r}) - {8'h00, r}) | {8'h00, r};
    notes.push_back(18'h30000);
    start_run(16'h0000);
    fork
      host_acc(1'b0, 1'b0, 16'h0033, 16'h0069);
    join_none
    k = 0;
    do @(negedge clk_sys); while (!hostIrq && ++k < 300);
    wait fork;
    @(negedge clk_sys);
    check("status after stop", {13'h0, statusFlags}, 16'h0004);
    host_acc(1'b1, 1'b0, 16'h0000, x);
    @(posedge clk_sys);
    hostStatusRd <= 1'b1;
    @(posedge clk_sys);
    hostStatusRd <= 1'b0;
    @(negedge clk_sys);
    check("irq after status read", {15'h0, hostIrq}, 16'h0000);
    $display("test run and stop done");
    // code above the cache comes over the rom port; this byte decodes as stop
    notes.push_back(18'h30000);
    start_run(16'h025a);
    k = 0;
    do @(negedge clk_sys); while (!hostIrq && ++k < 300);
    @(negedge clk_sys);
    check("status after fetched stop", {13'h0, statusFlags}, 16'h0004);
    @(posedge clk_sys);
    hostStatusRd <= 1'b1;
    @(posedge clk_sys);
    hostStatusRd <= 1'b0;
    $display("test rom fetch done");
    start_run(16'h0000);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b0;
    @(negedge clk_sys);
    check("status in reset", {12'h0, hostIrq, statusFlags}, 16'h0000);
    check("rom request in reset", {15'h0, romReq}, 16'h0000);
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    host_acc(1'b1, 1'b0, 16'h0000, x);
    check("pending notes", 16'(notes.size()), 16'h0000);
    $display("test reset mid-run done");
    give_verdict();
  end
endmodule
`default_nettype wire
